// ===== tally_counter.sv
// One wrapping time tally: counts 0..MAX on each step and flags the wrap.
// Assumes step, load and clear come from logic on the same clock.
module tally_counter #(
    parameter logic [7:0] MAX = 8'h3b
) (
    input wire logic core_clk,
    input wire logic reset,
    tally_if.cnt     port
);

    typedef struct packed {
        logic [7:0] value;
    } state_s;

    state_s s_q;
    state_s s_d;

    // Wrap is a one-cycle carry into the next tally
    assign port.wrap  = port.step & (s_q.value == MAX);
    assign port.value = s_q.value;

    // Clear wins over load, load over step
    always_comb begin
        s_d = s_q;
        if (port.clear) begin
            s_d.value = tic_pkg::TALLY_RESET;
        end else if (port.load) begin
            s_d.value = port.load_val;
        end else if (port.step) begin
            s_d.value = (s_q.value == MAX) ? tic_pkg::TALLY_RESET : s_q.value + 8'h01;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '{value: tic_pkg::TALLY_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_tally_in_range: assert property (s_q.value <= MAX)
        else $error("Tally above its last value");

    a_tally_wraps_zero: assert property (port.wrap && !port.clear && !port.load |=> s_q.value == 8'h00)
        else $error("Tally did not wrap to zero");

endmodule

// ===== tally_if.sv
// Link between the interval counter core and one time tally counter.
// Assumes both ends run on the same core clock.
interface tally_if;
    logic       step;
    logic       load;
    logic       clear;
    logic [7:0] load_val;
    logic [7:0] value;
    logic       wrap;

    modport ctrl (output step, load, clear, load_val, input value, wrap);
    modport cnt  (input step, load, clear, load_val, output value, wrap);
endinterface

// ===== tb_time_interval_counter.sv
// Self-checking bench for the time interval counter: tallies, carries, base select, match modes.
// Assumes the design's register port answers one cycle after a read strobe and never stalls.
module tb_time_interval_counter;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int T = 16; // Fraction step period in core cycles
    logic       core_clk = 1'b0;
    logic       reset    = 1'b1;
    logic [7:0] addr     = 8'h00;
    logic [7:0] wdata    = 8'h00;
    logic       wr_stb   = 1'b0;
    logic       rd_stb   = 1'b0;
    logic [7:0] rdata;
    logic       interval_flag;
    int         miscompares = 0;
    int         checks      = 0;
    int         cyc         = 0;
    int         t1;

    time_interval_counter #(.FRAC_TICK_CYCLES(T)) u_dut (
        .core_clk      (core_clk),
        .reset         (reset),
        .addr          (addr),
        .wdata         (wdata),
        .wr_stb        (wr_stb),
        .rd_stb        (rd_stb),
        .rdata         (rdata),
        .interval_flag (interval_flag)
    );

    // Clock and hang guard
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        @(posedge core_clk);
    endtask

    // Read strobe, then data judged in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(posedge core_clk);
        check($sformatf("reg %h", a), rdata, exp);
    endtask

    // Waits at most lim cycles for the flag
    task automatic wait_flag(input int lim);
        for (int n = 0; n < lim && interval_flag !== 1'b1; n++) begin
            @(posedge core_clk);
        end
    endtask

    task automatic reset_values();
        for (int i = 1; i < 7; i++) begin
            rd(8'ha0 + 8'(i), 8'h00);
        end
        rd(8'ha0, 8'h00);
    endtask

    task automatic tally_chain();
        wr(tic_pkg::FRAC_ADDR, 8'h7f);
        wr(tic_pkg::SEC_ADDR, 8'h3b);
        wr(tic_pkg::MIN_ADDR, 8'h3b);
        wr(tic_pkg::HOUR_ADDR, 8'h17);
        rd(tic_pkg::HOUR_ADDR, 8'h17);
        wr(tic_pkg::CTRL_ADDR, 8'h41);
        repeat (T + 4) @(posedge core_clk);
        rd(tic_pkg::HOUR_ADDR, 8'h00);
        rd(tic_pkg::MIN_ADDR, 8'h00);
        rd(tic_pkg::SEC_ADDR, 8'h00);
        rd(tic_pkg::FRAC_ADDR, 8'h00);
        wr(tic_pkg::SEC_ADDR, 8'h05);
        rd(tic_pkg::SEC_ADDR, 8'h00);
        repeat (3 * T) @(posedge core_clk);
        wr(tic_pkg::CTRL_ADDR, 8'hc0);
        rd(tic_pkg::FRAC_ADDR, 8'h00);
        rd(tic_pkg::CTRL_ADDR, 8'h40);
    endtask

    // Each base makes the timebase tick or a different register's wrap the interval step
    task automatic base_select();
        for (int s = 0; s < 4; s++) begin
            wr(tic_pkg::CTRL_ADDR, 8'h40);
            wr(tic_pkg::FRAC_ADDR, 8'h7e);
            wr(tic_pkg::SEC_ADDR, (s >= 2) ? 8'h3b : 8'h00);
            wr(tic_pkg::MIN_ADDR, (s == 3) ? 8'h3b : 8'h00);
            wr(tic_pkg::TARGET_ADDR, 8'h01);
            wr(tic_pkg::CTRL_ADDR, 8'h43 | 8'(s << 4));
            wait_flag(3 * T);
            rd(tic_pkg::FRAC_ADDR, (s == 0) ? 8'h7f : 8'h00);
            rd(tic_pkg::SEC_ADDR, (s == 1) ? 8'h01 : 8'h00);
            rd(tic_pkg::MIN_ADDR, (s == 2) ? 8'h01 : 8'h00);
            rd(tic_pkg::HOUR_ADDR, (s == 3) ? 8'h01 : 8'h00);
        end
    endtask

    task automatic repeat_mode();
        wr(tic_pkg::CTRL_ADDR, 8'h40);
        wr(tic_pkg::TARGET_ADDR, 8'h03);
        wr(tic_pkg::CTRL_ADDR, 8'h43);
        wait_flag(4 * T);
        t1 = cyc;
        repeat (20) @(posedge core_clk);
        check("flag held", {7'h00, interval_flag}, 8'h01);
        wr(tic_pkg::CTRL_ADDR, 8'h43);
        wait_flag(4 * T);
        check("period", 8'(cyc - t1), 8'(3 * T));
        wr(tic_pkg::CTRL_ADDR, 8'h43);
        repeat (2 * T) @(posedge core_clk);
        wr(tic_pkg::CTRL_ADDR, 8'h41);
        wr(tic_pkg::CTRL_ADDR, 8'h43);
        wait_flag(2 * T);
        check("flag early", {7'h00, interval_flag}, 8'h00);
        wait_flag(2 * T);
        check("flag late", {7'h00, interval_flag}, 8'h01);
    endtask

    task automatic single_shot();
        wr(tic_pkg::CTRL_ADDR, 8'h40);
        wr(tic_pkg::TARGET_ADDR, 8'h02);
        wr(tic_pkg::CTRL_ADDR, 8'h4b);
        wait_flag(3 * T);
        rd(tic_pkg::CTRL_ADDR, 8'h4d);
        wr(tic_pkg::CTRL_ADDR, 8'h49);
        wait_flag(4 * T);
        check("shot flag", {7'h00, interval_flag}, 8'h00);
        wr(tic_pkg::TARGET_ADDR, 8'hff);
        rd(tic_pkg::TARGET_ADDR, 8'hff);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        reset_values();
        tally_chain();
        base_select();
        repeat_mode();
        single_shot();
        test_done();
    end
endmodule

// ===== tic_pkg.sv
// Constants shared by the time interval counter and its tally counters.
// Assumes a single 40 MHz core clock that also stands in for the timebase.
package tic_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] CTRL_ADDR   = 8'ha1;
    localparam logic [7:0] FRAC_ADDR   = 8'ha2;
    localparam logic [7:0] SEC_ADDR    = 8'ha3;
    localparam logic [7:0] MIN_ADDR    = 8'ha4;
    localparam logic [7:0] HOUR_ADDR   = 8'ha5;
    localparam logic [7:0] TARGET_ADDR = 8'ha6;

    // Control register field positions
    localparam int BIT_TIME_CLOCK_ENABLE    = 0;
    localparam int BIT_INTERVAL_ENABLE    = 1;
    localparam int BIT_FLAG    = 2;
    localparam int BIT_SHOT    = 3;
    localparam int BIT_SEL_LO  = 4;
    localparam int BIT_SEL_HI  = 5;
    localparam int BIT_RSV_ONE = 6;

    // Bits that software can write and read back; bit 7 reads zero
    localparam logic [7:0] CTRL_WMASK = 8'h7f;

    // Values after reset
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] TALLY_RESET  = 8'h00;
    localparam logic [7:0] TARGET_RESET = 8'h00;

    // Last value of each tally before it wraps: fraction, seconds, minutes, hours
    localparam int NUM_TALLY = 4;
    localparam logic [7:0] TALLY_MAX [NUM_TALLY] = '{8'h7f, 8'h3b, 8'h3b, 8'h17};

    // Timebase: one fraction step every 1/128 second
    localparam longint FRAC_DIV         = 128;
    localparam longint FRAC_PERIOD_NS   = 64'd1_000_000_000 / FRAC_DIV;
    localparam longint CLK_PERIOD_NS    = 25;
    localparam int     FRAC_TICK_CYCLES = int'(FRAC_PERIOD_NS / CLK_PERIOD_NS);

    // Interval timebase selection
    typedef enum logic [1:0] {
        BASE_FRAC = 2'b00,
        BASE_SEC  = 2'b01,
        BASE_MIN  = 2'b10,
        BASE_HOUR = 2'b11
    } base_sel_e;

endpackage

// ===== time_interval_counter.sv
// Time interval counter: fraction, seconds, minutes, hours and an interval match.
// Assumes a core register port with one-cycle strobes; the core maps the flag
// onto its interrupt enable, wake-up and vector logic.
module time_interval_counter #(
    parameter int FRAC_TICK_CYCLES = tic_pkg::FRAC_TICK_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    output logic            interval_flag
);

    localparam logic [23:0] PRESCALE_LAST = 24'(FRAC_TICK_CYCLES - 1);

    typedef struct packed {
        logic [23:0] prescale;
        logic [7:0]  ctrl;
        logic [7:0]  target;
        logic [7:0]  icount;
        logic [7:0]  rdata;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic                 time_clock_enable;
    logic                 interval_enable;
    logic                 shot;
    tic_pkg::base_sel_e   base_sel;
    logic                 frac_tick;
    logic                 ival_tick;
    logic [7:0]           icount_inc;
    logic                 match;
    logic                 ctrl_wr;
    logic                 time_clear;
    logic [7:0]           tally_val [tic_pkg::NUM_TALLY];

    tally_if tally [tic_pkg::NUM_TALLY] ();

    // Control fields
    assign time_clock_enable     = s_q.ctrl[tic_pkg::BIT_TIME_CLOCK_ENABLE];
    assign interval_enable     = s_q.ctrl[tic_pkg::BIT_INTERVAL_ENABLE];
    assign shot     = s_q.ctrl[tic_pkg::BIT_SHOT];
    assign base_sel = tic_pkg::base_sel_e'(s_q.ctrl[tic_pkg::BIT_SEL_HI:tic_pkg::BIT_SEL_LO]);
    assign ctrl_wr  = wr_stb & (addr == tic_pkg::CTRL_ADDR);

    // Timebase tick every 1/128 s, only while the time clock is enabled
    assign frac_tick = time_clock_enable & (s_q.prescale == PRESCALE_LAST);

    // Clearing the time clock enable clears the time registers
    assign time_clear = ctrl_wr & time_clock_enable & ~wdata[tic_pkg::BIT_TIME_CLOCK_ENABLE];

    // Tally chain: each wrap steps the next tally, hours wrap with no carry
    for (genvar i = 0; i < tic_pkg::NUM_TALLY; i++) begin : g_tally
        if (i == 0) begin : g_first
            assign tally[i].step = frac_tick;
        end else begin : g_next
            assign tally[i].step = tally[i-1].wrap;
        end
        // Time registers take software writes only while the clock is off
        assign tally[i].load     = wr_stb & ~time_clock_enable & (addr == tic_pkg::FRAC_ADDR + 8'(i));
        assign tally[i].clear    = time_clear;
        assign tally[i].load_val = wdata;
        assign tally_val[i]      = tally[i].value;

        tally_counter #(
            .MAX (tic_pkg::TALLY_MAX[i])
        ) u_tally (
            .core_clk (core_clk),
            .reset    (reset),
            .port     (tally[i])
        );
    end

    // Interval step from the timebase tick or the overflow of the time register below the selected one
    always_comb begin
        case (base_sel)
            tic_pkg::BASE_FRAC: ival_tick = frac_tick;
            tic_pkg::BASE_SEC:  ival_tick = tally[0].wrap;
            tic_pkg::BASE_MIN:  ival_tick = tally[1].wrap;
            tic_pkg::BASE_HOUR: ival_tick = tally[2].wrap;
            default:            ival_tick = 1'b0;
        endcase
    end

    // Match is judged on the value the counter takes at this step
    assign icount_inc = s_q.icount + 8'h01;
    assign match      = ival_tick & interval_enable & (icount_inc == s_q.target);

    // Next state: prescaler, control, target, interval counter, read data
    always_comb begin
        s_d = s_q;

        // Prescaler held at zero while the time clock is off
        if (!time_clock_enable || s_q.prescale == PRESCALE_LAST) begin
            s_d.prescale = 24'h000000;
        end else begin
            s_d.prescale = s_q.prescale + 24'h000001;
        end

        // Control write; reserved bit 6 is stored as written, bit 7 reads zero
        if (ctrl_wr) begin
            s_d.ctrl = wdata & tic_pkg::CTRL_WMASK;
        end

        // Flag: a match in the same cycle as a software clear still sets it
        s_d.ctrl[tic_pkg::BIT_FLAG] = match | s_d.ctrl[tic_pkg::BIT_FLAG];

        // Single shot stops the interval counter at the timeout
        if (match && shot) begin
            s_d.ctrl[tic_pkg::BIT_INTERVAL_ENABLE] = 1'b0;
        end

        // Target takes any 8-bit value
        if (wr_stb && addr == tic_pkg::TARGET_ADDR) begin
            s_d.target = wdata;
        end

        // Interval counter: zero when disabled, reload on match, else step
        if (!interval_enable) begin
            s_d.icount = 8'h00;
        end else if (match) begin
            s_d.icount = 8'h00;
        end else if (ival_tick) begin
            s_d.icount = icount_inc;
        end

        // Read data stands for the one cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd_stb) begin
            case (addr)
                tic_pkg::CTRL_ADDR:   s_d.rdata = s_q.ctrl;
                tic_pkg::FRAC_ADDR:   s_d.rdata = tally_val[0];
                tic_pkg::SEC_ADDR:    s_d.rdata = tally_val[1];
                tic_pkg::MIN_ADDR:    s_d.rdata = tally_val[2];
                tic_pkg::HOUR_ADDR:   s_d.rdata = tally_val[3];
                tic_pkg::TARGET_ADDR: s_d.rdata = s_q.target;
                default:              s_d.rdata = 8'h00;
            endcase
        end
    end

    // State register; everything clears on reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '{prescale: 24'h000000,
                     ctrl:     tic_pkg::CTRL_RESET,
                     target:   tic_pkg::TARGET_RESET,
                     icount:   8'h00,
                     rdata:    8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign rdata         = s_q.rdata;
    assign interval_flag = s_q.ctrl[tic_pkg::BIT_FLAG];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Interval match and what follows it
    sequence s_match;
        ival_tick && interval_enable && icount_inc == s_q.target;
    endsequence

    sequence s_restart;
        s_q.icount == 8'h00 ##1 s_q.icount == 8'h00 || s_q.icount == 8'h01 || !interval_enable;
    endsequence

    a_flag_on_match: assert property (s_match |=> interval_flag)
        else $error("Flag not set after a match");

    a_flag_sticky: assert property (interval_flag && !ctrl_wr |=> interval_flag)
        else $error("Flag cleared without a software write");

    a_single_shot: assert property (s_match and shot |=> !interval_enable ##1 s_q.icount == 8'h00)
        else $error("Single shot did not stop the interval counter");

    // A software write of the control register at the match may clear the enable legally
    a_repeat_reload: assert property (s_match ##0 !shot && !ctrl_wr |=> interval_enable ##0 s_restart)
        else $error("Repeat mode did not reload the interval counter");

    a_disable_zeroes: assert property (!interval_enable |=> s_q.icount == 8'h00)
        else $error("Interval counter not cleared while disabled");

    a_time_clear: assert property (time_clear |=> tally_val[0] == 8'h00 && tally_val[3] == 8'h00)
        else $error("Time registers not cleared when the time clock stops");

    a_gate_frozen: assert property (!time_clock_enable && !wr_stb |=> $stable(tally_val[0]) && $stable(tally_val[1]))
        else $error("Time registers moved while the time clock was off");

    a_frac_carry: assert property (tally[0].wrap && tally_val[1] < 8'h3b && !wr_stb
                                   |=> tally_val[0] == 8'h00 && tally_val[1] == $past(tally_val[1]) + 8'h01)
        else $error("Fraction wrap did not step the seconds");

    a_tick_spacing: assert property (frac_tick |=> !frac_tick [*2])
        else $error("Timebase ticks too close together");

    a_read_unmapped: assert property (rd_stb && (addr < tic_pkg::CTRL_ADDR || addr > tic_pkg::TARGET_ADDR)
                                      |=> rdata == 8'h00 ##1 rdata == 8'h00 || $past(rd_stb))
        else $error("Unmapped read returned data");

    // Register port: read data stands one cycle and shows the addressed register
    a_read_idle: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("Read data stood without a read strobe");

    a_read_ctrl: assert property (rd_stb && addr == tic_pkg::CTRL_ADDR |=> rdata == $past(s_q.ctrl))
        else $error("Control read returned the wrong value");

    a_read_frac: assert property (rd_stb && addr == tic_pkg::FRAC_ADDR |=> rdata == $past(tally_val[0]))
        else $error("Fraction read returned the wrong value");

    a_read_sec: assert property (rd_stb && addr == tic_pkg::SEC_ADDR |=> rdata == $past(tally_val[1]))
        else $error("Seconds read returned the wrong value");

    a_read_min: assert property (rd_stb && addr == tic_pkg::MIN_ADDR |=> rdata == $past(tally_val[2]))
        else $error("Minutes read returned the wrong value");

    a_read_hour: assert property (rd_stb && addr == tic_pkg::HOUR_ADDR |=> rdata == $past(tally_val[3]))
        else $error("Hours read returned the wrong value");

    a_read_target: assert property (rd_stb && addr == tic_pkg::TARGET_ADDR |=> rdata == $past(s_q.target))
        else $error("Target read returned the wrong value");

    a_target_write: assert property (wr_stb && addr == tic_pkg::TARGET_ADDR |=> s_q.target == $past(wdata))
        else $error("Target did not take the written value");

    a_bit7_zero: assert property (s_q.ctrl[7] == 1'b0)
        else $error("Control bit 7 is not zero");

    a_rsv_stored: assert property (ctrl_wr |=> s_q.ctrl[tic_pkg::BIT_RSV_ONE] == $past(wdata[tic_pkg::BIT_RSV_ONE]))
        else $error("Reserved control bit not stored as written");

    // Time registers: preload while stopped, refused while running, carries in order
    a_load_open: assert property (wr_stb && !time_clock_enable && addr == tic_pkg::SEC_ADDR |=> tally_val[1] == $past(wdata))
        else $error("Seconds preload was not taken");

    a_load_refused: assert property (wr_stb && time_clock_enable && addr == tic_pkg::MIN_ADDR && !tally[1].wrap
                                     |=> $stable(tally_val[2]))
        else $error("Minutes took a write while the time clock ran");

    a_prescale_hold: assert property (!time_clock_enable |=> s_q.prescale == 24'h000000)
        else $error("Timebase ran while the time clock was off");

    a_clear_middle: assert property (time_clear |=> tally_val[1] == 8'h00 && tally_val[2] == 8'h00)
        else $error("Seconds or minutes not cleared when the time clock stops");

    a_min_carry: assert property (tally[1].wrap && !wr_stb
                                  |=> tally_val[1] == 8'h00
                                      && tally_val[2] == ($past(tally_val[2]) == 8'h3b ? 8'h00
                                                                                         : $past(tally_val[2]) + 8'h01))
        else $error("Seconds wrap did not step the minutes");

    a_hour_carry: assert property (tally[2].wrap && !wr_stb
                                   |=> tally_val[3] == ($past(tally_val[3]) == 8'h17 ? 8'h00
                                                                                      : $past(tally_val[3]) + 8'h01))
        else $error("Minutes wrap did not step the hours");

    // Interval counter: while enabled, moves only on the selected timebase tick or overflow
    sequence s_quiet;
        interval_enable && !ival_tick;
    endsequence

    sequence s_plain_step;
        interval_enable && ival_tick && !match;
    endsequence

    a_count_hold: assert property (s_quiet |=> $stable(s_q.icount))
        else $error("Interval counter moved without a step");

    a_count_step: assert property (s_plain_step |=> s_q.icount == $past(icount_inc))
        else $error("Interval counter did not step");

    a_base_frac: assert property (base_sel == tic_pkg::BASE_FRAC |-> ival_tick == frac_tick)
        else $error("Fraction base did not step on the timebase tick");

    a_base_hour: assert property (base_sel == tic_pkg::BASE_HOUR |-> ival_tick == tally[2].wrap)
        else $error("Hour base did not step on the minutes wrap");

    a_flag_source: assert property (!interval_flag && !ctrl_wr && !match |=> !interval_flag)
        else $error("Flag rose without a match or a write");

endmodule
